// ==== shared/somc_pkg.sv ====
package somc_pkg;

	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_STARTUP_US  = 1000;
	localparam int T_SYSTEM_RESET_LINE_LOW_US = 20;
	localparam int SPI_FRAME_BITS = 16;

	// Register addresses
	localparam logic [6:0] ADDR_MODE_CTRL   = 7'h01;
	localparam logic [6:0] ADDR_MAIN_STATUS = 7'h03;
	localparam logic [6:0] ADDR_NV_CFG      = 7'h74;

	// Operating mode field codes and reset value
	localparam logic [2:0] MC_STANDBY   = 3'h4;
	localparam logic [2:0] MC_NORMAL    = 3'h7;
	localparam logic [2:0] MC_RESET_VAL = 3'h4;

	// Main status field positions
	localparam int STAT_OVERTEMP_WARNING_STATUS_BIT = 6;
	localparam int STAT_NMS_BIT  = 5;

	// Reset source codes
	localparam logic [4:0] RSS_POWER_ON   = 5'h00;
	localparam logic [4:0] RSS_WD_EARLY   = 5'h0E;
	localparam logic [4:0] RSS_WD_OVERFL  = 5'h0F;
	localparam logic [4:0] RSS_WD_ILLEGAL = 5'h10;
	localparam logic [4:0] RSS_EXT_PULL   = 5'h11;
	localparam logic [4:0] RSS_OTP_EXIT   = 5'h12;
	localparam logic [4:0] RSS_V1_UV      = 5'h13;

	// Non-volatile configuration
	localparam int         NV_FORCED_NORMAL_SELECT_BIT  = 0;
	localparam logic [7:0] NV_CFG_RESET = 8'h01;

	// Watchdog and CAN mode field codes
	localparam logic [2:0] WMC_AUTO    = 3'h1;
	localparam logic [2:0] WMC_TIMEOUT = 3'h2;
	localparam logic [2:0] WMC_WINDOW  = 3'h4;
	localparam logic [1:0] CMC_OFFLINE = 2'h0;
	localparam logic [1:0] CMC_LISTEN  = 2'h3;

	// Positions of the synchronised pin inputs
	localparam int PIN_BAT_ON  = 0;
	localparam int PIN_BAT_OFF = 1;
	localparam int PIN_OTP_ACT = 2;
	localparam int PIN_OTP_REL = 3;
	localparam int PIN_WARN    = 4;
	localparam int PIN_UV      = 5;
	localparam int PIN_SYSTEM_RESET_LINE    = 6;
	localparam int PIN_CANRX   = 7;
	localparam int PIN_COUNT   = 8;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_BOOT,
		ST_RESET,
		ST_STANDBY,
		ST_NORMAL,
		ST_FNM,
		ST_OVERTEMP
	} somc_state_e;

endpackage

// ==== rtl/somc_spi_slave.sv ====
`timescale 1ns/1ps
module somc_spi_slave (
	input  wire logic       ref_clk_i,
	input  wire logic       srst_i,
	input  wire logic       sck_i,
	input  wire logic       cs_n_i,
	input  wire logic       sdi_i,
	input  wire logic       enable_i,
	input  wire logic [7:0] rd_data_i,
	output logic      [6:0] addr_o,
	output logic            wr_stb_o,
	output logic      [7:0] wr_data_o,
	output logic            sdo_o,
	output logic            sdo_oe_o
);
	import somc_pkg::*;

	logic [2:0]  s1_reg;
	logic [2:0]  s2_reg;
	logic        sck_d_reg;
	logic        cs_d_reg;
	logic [15:0] shift_reg;
	logic [4:0]  cnt_reg;
	logic        ro_reg;
	logic        load_reg;
	logic [7:0]  out_reg;
	logic        sck_rise;
	logic        sck_fall;
	logic        cs_rise;

	// Two-stage synchronisers: sck, cs_n, sdi
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			s1_reg    <= 3'h2;
			s2_reg    <= 3'h2;
			sck_d_reg <= 1'b0;
			cs_d_reg  <= 1'b1;
		end else begin
			s1_reg    <= {sdi_i, cs_n_i, sck_i};
			s2_reg    <= s1_reg;
			sck_d_reg <= s2_reg[0];
			cs_d_reg  <= s2_reg[1];
		end
	end

	assign sck_rise = s2_reg[0] & ~sck_d_reg & ~s2_reg[1];
	assign sck_fall = ~s2_reg[0] & sck_d_reg & ~s2_reg[1];
	assign cs_rise  = s2_reg[1] & ~cs_d_reg;

	// Frame: address 7 bits, read-only flag, 8 data bits, MSB first
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || s2_reg[1]) begin
			cnt_reg   <= 5'h00;
			shift_reg <= 16'h0000;
		end else if (sck_rise) begin
			shift_reg <= {shift_reg[14:0], s2_reg[2]};
			if (cnt_reg != 5'h1F) begin
				cnt_reg <= cnt_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			addr_o   <= 7'h00;
			ro_reg   <= 1'b0;
			load_reg <= 1'b0;
		end else begin
			load_reg <= sck_rise && (cnt_reg == 5'h07);
			if (load_reg) begin
				addr_o <= shift_reg[7:1];
				ro_reg <= shift_reg[0];
			end
		end
	end

	// Read data is taken one cycle after the address is latched
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			out_reg <= 8'h00;
			sdo_o   <= 1'b0;
		end else if (s2_reg[1]) begin
			sdo_o <= 1'b0;
		end else if (sck_fall && cnt_reg >= 5'h08) begin
			sdo_o   <= out_reg[7];
			out_reg <= {out_reg[6:0], 1'b0};
		end else if (cnt_reg == 5'h08 && !sck_rise && !load_reg
				&& sck_d_reg) begin
			out_reg <= rd_data_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			wr_stb_o  <= 1'b0;
			wr_data_o <= 8'h00;
			sdo_oe_o  <= 1'b0;
		end else begin
			sdo_oe_o <= ~s2_reg[1] & enable_i;
			wr_stb_o <= cs_rise && enable_i && !ro_reg
				&& (cnt_reg == 5'(SPI_FRAME_BITS));
			if (cs_rise) begin
				wr_data_o <= shift_reg[7:0];
			end
		end
	end

endmodule

// ==== rtl/somc_mode_ctrl.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Reset mode: CAN offline unless entered from Forced Normal, SPI off, watchdog off, regulator on, reset low.
// - Any reset event from an active mode forces Reset mode.
// - Reset line released high with selection zero: go to Standby.
// - Forced-normal selection one: leave Reset for Forced Normal instead.
// - Undervoltage-caused Reset holds until regulator voltage recovers.
// - Low battery forces Off from any mode; Off keeps everything off.
// - Battery above power-on threshold: start-up delay, then Reset mode.
// - Overtemperature activation forces Overtemp from any mode except Off and the start-up delay.
// - Warning sets status bit; event captured only when enabled.
// - Overtemp disables CAN; pending wake-up still pulls receive output low.
// - Overtemp switches regulator off and drives reset line low.
// - Overtemp exits to Reset below release threshold, Off on low battery.
// - Forced Normal: watchdog off, regulator and CAN transceiver active.
// - Forced-normal bit lives in non-volatile register, factory value one.
// - Reset from Forced Normal keeps transmitter on unless undervoltage.
// - Forced Normal reads limited; non-volatile writable in factory state.
// - Normal mode CAN follows CAN mode field; receive stream for nonzero.
// - Watchdog per mode field in Standby/Normal; window only in Normal.
// - Mode field bits 2:0 at 01h: 100 Standby, 111 Normal.
// - Main status bit 6 shows warning level; bit 7 reads zero.
// - Main status bits 4:0 hold the last reset source code.
// - Main status bit 5 is one until Normal mode is first entered.
module somc_mode_ctrl #(
	parameter int STARTUP_CYCLES =
		(somc_pkg::T_STARTUP_US * 1000 + somc_pkg::CLK_PERIOD_NS - 1)
		/ somc_pkg::CLK_PERIOD_NS
) (
	input  wire logic       ref_clk_i,
	input  wire logic       srst_i,
	input  wire logic       battery_above_poweron_i,
	input  wire logic       battery_below_poweroff_i,
	input  wire logic       temp_above_otp_act_i,
	input  wire logic       temp_below_otp_rel_i,
	input  wire logic       temp_above_warn_i,
	input  wire logic       regulator_undervolt_i,
	input  wire logic       system_reset_line_i,
	output logic            system_reset_line_o,
	output logic            system_reset_line_oe_o,
	input  wire logic       wd_early_trigger_i,
	input  wire logic       wd_overflow_i,
	input  wire logic       wd_illegal_cfg_i,
	input  wire logic       wake_pending_i,
	input  wire logic [1:0] can_mode_field_i,
	input  wire logic [2:0] watchdog_mode_field_i,
	input  wire logic       overtemp_warning_enable_i,
	input  wire logic       overtemp_warning_clear_i,
	input  wire logic       can_rx_bus_i,
	input  wire logic       spi_sck_i,
	input  wire logic       spi_cs_n_i,
	input  wire logic       spi_sdi_i,
	output logic            spi_sdo_o,
	output logic            spi_sdo_oe_o,
	output logic            host_regulator_output_en_o,
	output logic            can_tx_en_o,
	output logic            can_rx_en_o,
	output logic            can_rxd_o,
	output logic            watchdog_run_o,
	output logic            watchdog_window_o,
	output logic            overtemp_warning_status_o,
	output logic            overtemp_warning_event_o
);
	import somc_pkg::*;

	localparam int SYSTEM_RESET_LINE_LOW_CYCLES =
		(T_SYSTEM_RESET_LINE_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	somc_state_e    state_reg;
	somc_state_e    state_next;
	logic [4:0]     src_reg;
	logic [4:0]     src_next;
	logic           uv_cause_reg;
	logic           uv_cause_next;
	logic           from_fnm_reg;
	logic [PIN_COUNT-1:0] sync1_reg;
	logic [PIN_COUNT-1:0] pin_s;
	logic [23:0]    timer_reg;
	logic [2:0]     operating_mode_field_reg;
	logic           normal_entry_pending_reg;
	logic [7:0]     nv_cfg_reg;
	logic           nv_factory_reg;
	logic           warn_d_reg;
	logic           forced_normal_select;
	logic           rst_drive;
	logic           active_mode;
	logic           ext_pull;
	logic           mc_write;
	logic           nv_write;
	logic           spi_enable;
	logic [6:0]     spi_addr;
	logic           spi_wr_stb;
	logic [7:0]     spi_wr_data;
	logic [7:0]     rd_data;

	// Two-stage synchronisers for every pin input
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			sync1_reg <= '0;
			pin_s     <= '0;
		end else begin
			sync1_reg <= {can_rx_bus_i, system_reset_line_i,
				regulator_undervolt_i, temp_above_warn_i,
				temp_below_otp_rel_i, temp_above_otp_act_i,
				battery_below_poweroff_i, battery_above_poweron_i};
			pin_s     <= sync1_reg;
		end
	end

	assign forced_normal_select = nv_cfg_reg[NV_FORCED_NORMAL_SELECT_BIT];
	assign active_mode = (state_reg == ST_STANDBY)
		|| (state_reg == ST_NORMAL) || (state_reg == ST_FNM);
	assign ext_pull = active_mode && !pin_s[PIN_SYSTEM_RESET_LINE];
	assign rst_drive = (timer_reg < 24'(SYSTEM_RESET_LINE_LOW_CYCLES))
		|| (uv_cause_reg && pin_s[PIN_UV]);
	assign spi_enable = active_mode;
	assign mc_write = spi_wr_stb && (spi_addr == ADDR_MODE_CTRL)
		&& (state_reg != ST_FNM)
		&& ((spi_wr_data[2:0] == MC_STANDBY)
		|| (spi_wr_data[2:0] == MC_NORMAL));
	assign nv_write = spi_wr_stb && (spi_addr == ADDR_NV_CFG)
		&& nv_factory_reg;

	// Mode transitions, highest priority first
	always_comb begin
		state_next    = state_reg;
		src_next      = src_reg;
		uv_cause_next = uv_cause_reg;
		if (pin_s[PIN_BAT_OFF]) begin
			state_next = ST_OFF;
		end else begin
			case (state_reg)
				ST_OFF: begin
					if (pin_s[PIN_BAT_ON]) begin
						state_next = ST_BOOT;
					end
				end
				ST_BOOT: begin
					if (timer_reg >= 24'(STARTUP_CYCLES - 1)) begin
						state_next    = ST_RESET;
						src_next      = RSS_POWER_ON;
						uv_cause_next = 1'b0;
					end
				end
				ST_OVERTEMP: begin
					if (pin_s[PIN_OTP_REL]) begin
						state_next    = ST_RESET;
						src_next      = RSS_OTP_EXIT;
						uv_cause_next = 1'b0;
					end
				end
				default: begin
					if (pin_s[PIN_OTP_ACT]) begin
						state_next = ST_OVERTEMP;
					end else if (state_reg == ST_RESET) begin
						if (!rst_drive && pin_s[PIN_SYSTEM_RESET_LINE]) begin
							state_next = forced_normal_select
								? ST_FNM : ST_STANDBY;
						end
					end else if (pin_s[PIN_UV]) begin
						state_next    = ST_RESET;
						src_next      = RSS_V1_UV;
						uv_cause_next = 1'b1;
					end else if (wd_illegal_cfg_i) begin
						state_next    = ST_RESET;
						src_next      = RSS_WD_ILLEGAL;
						uv_cause_next = 1'b0;
					end else if (wd_overflow_i) begin
						state_next    = ST_RESET;
						src_next      = RSS_WD_OVERFL;
						uv_cause_next = 1'b0;
					end else if (wd_early_trigger_i) begin
						state_next    = ST_RESET;
						src_next      = RSS_WD_EARLY;
						uv_cause_next = 1'b0;
					end else if (ext_pull) begin
						state_next    = ST_RESET;
						src_next      = RSS_EXT_PULL;
						uv_cause_next = 1'b0;
					end else if (mc_write) begin
						if (state_reg == ST_STANDBY
							&& spi_wr_data[2:0] == MC_NORMAL) begin
							state_next = ST_NORMAL;
						end else if (state_reg == ST_NORMAL
							&& spi_wr_data[2:0] == MC_STANDBY) begin
							state_next = ST_STANDBY;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state_reg    <= ST_OFF;
			src_reg      <= RSS_POWER_ON;
			uv_cause_reg <= 1'b0;
			from_fnm_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			src_reg      <= src_next;
			uv_cause_reg <= uv_cause_next;
			if (state_next == ST_RESET && state_reg != ST_RESET) begin
				from_fnm_reg <= (state_reg == ST_FNM);
			end
		end
	end

	// Cycles spent in the present state; restarts on every change
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || state_next != state_reg) begin
			timer_reg <= 24'h000000;
		end else if (timer_reg != 24'hFFFFFF) begin
			timer_reg <= timer_reg + 24'h000001;
		end
	end

	// Stored mode field and normal-entry flag
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			operating_mode_field_reg <= MC_RESET_VAL;
			normal_entry_pending_reg <= 1'b1;
		end else begin
			if (mc_write && (state_reg == ST_STANDBY
				|| state_reg == ST_NORMAL)) begin
				operating_mode_field_reg <= spi_wr_data[2:0];
			end else if (state_reg == ST_RESET
				&& state_next == ST_STANDBY) begin
				operating_mode_field_reg <= MC_STANDBY;
			end
			if (state_reg == ST_BOOT && state_next == ST_RESET) begin
				normal_entry_pending_reg <= 1'b1;
			end else if (state_next == ST_NORMAL) begin
				normal_entry_pending_reg <= 1'b0;
			end
		end
	end

	// Non-volatile configuration with factory preset
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			nv_cfg_reg     <= NV_CFG_RESET;
			nv_factory_reg <= 1'b1;
		end else if (nv_write) begin
			nv_cfg_reg <= spi_wr_data;
			if (!spi_wr_data[NV_FORCED_NORMAL_SELECT_BIT]) begin
				nv_factory_reg <= 1'b0;
			end
		end
	end

	// Warning status and captured event; a new event beats a clear
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			warn_d_reg                <= 1'b0;
			overtemp_warning_status_o <= 1'b0;
			overtemp_warning_event_o  <= 1'b0;
		end else begin
			warn_d_reg                <= pin_s[PIN_WARN];
			overtemp_warning_status_o <= pin_s[PIN_WARN];
			if (pin_s[PIN_WARN] && !warn_d_reg
				&& overtemp_warning_enable_i) begin
				overtemp_warning_event_o <= 1'b1;
			end else if (overtemp_warning_clear_i) begin
				overtemp_warning_event_o <= 1'b0;
			end
		end
	end

	// Register read decode
	always_comb begin
		rd_data = 8'h00;
		case (spi_addr)
			ADDR_MODE_CTRL: begin
				if (state_reg != ST_FNM) begin
					rd_data = {5'h00, operating_mode_field_reg};
				end
			end
			ADDR_MAIN_STATUS: begin
				rd_data = 8'h00;
				rd_data[STAT_OVERTEMP_WARNING_STATUS_BIT] = pin_s[PIN_WARN];
				rd_data[STAT_NMS_BIT]  = normal_entry_pending_reg;
				rd_data[4:0] = src_reg;
			end
			ADDR_NV_CFG: begin
				rd_data = nv_cfg_reg;
			end
			default: begin
				rd_data = 8'h00;
			end
		endcase
	end

	// Per-mode enables of regulator, reset line and CAN
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			host_regulator_output_en_o <= 1'b0;
			system_reset_line_o        <= 1'b0;
			system_reset_line_oe_o     <= 1'b1;
			can_tx_en_o                <= 1'b0;
			can_rx_en_o                <= 1'b0;
		end else begin
			system_reset_line_o <= 1'b0;
			case (state_reg)
				ST_RESET: begin
					host_regulator_output_en_o <= 1'b1;
					system_reset_line_oe_o     <= rst_drive;
					can_tx_en_o <= from_fnm_reg && !pin_s[PIN_UV];
					can_rx_en_o <= 1'b0;
				end
				ST_STANDBY: begin
					host_regulator_output_en_o <= 1'b1;
					system_reset_line_oe_o     <= 1'b0;
					can_tx_en_o                <= 1'b0;
					can_rx_en_o                <= 1'b0;
				end
				ST_NORMAL: begin
					host_regulator_output_en_o <= 1'b1;
					system_reset_line_oe_o     <= 1'b0;
					can_tx_en_o <= (can_mode_field_i != CMC_OFFLINE)
						&& (can_mode_field_i != CMC_LISTEN);
					can_rx_en_o <= (can_mode_field_i != CMC_OFFLINE);
				end
				ST_FNM: begin
					host_regulator_output_en_o <= 1'b1;
					system_reset_line_oe_o     <= 1'b0;
					can_tx_en_o                <= 1'b1;
					can_rx_en_o                <= 1'b1;
				end
				default: begin
					host_regulator_output_en_o <= 1'b0;
					system_reset_line_oe_o     <= 1'b1;
					can_tx_en_o                <= 1'b0;
					can_rx_en_o                <= 1'b0;
				end
			endcase
		end
	end

	// Receive output and watchdog operating mode
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			can_rxd_o         <= 1'b1;
			watchdog_run_o    <= 1'b0;
			watchdog_window_o <= 1'b0;
		end else begin
			if (state_reg == ST_FNM || (state_reg == ST_NORMAL
				&& can_mode_field_i != CMC_OFFLINE)) begin
				can_rxd_o <= pin_s[PIN_CANRX];
			end else if (state_reg == ST_OFF || state_reg == ST_BOOT) begin
				can_rxd_o <= 1'b1;
			end else begin
				can_rxd_o <= !wake_pending_i;
			end
			case (state_reg)
				ST_STANDBY: begin
					watchdog_window_o <= 1'b0;
					watchdog_run_o <= (watchdog_mode_field_i == WMC_WINDOW)
						|| (watchdog_mode_field_i == WMC_TIMEOUT)
						|| (watchdog_mode_field_i == WMC_AUTO
						&& wake_pending_i);
				end
				ST_NORMAL: begin
					watchdog_window_o <=
						(watchdog_mode_field_i == WMC_WINDOW);
					watchdog_run_o <= (watchdog_mode_field_i == WMC_WINDOW)
						|| (watchdog_mode_field_i == WMC_TIMEOUT)
						|| (watchdog_mode_field_i == WMC_AUTO);
				end
				default: begin
					watchdog_run_o    <= 1'b0;
					watchdog_window_o <= 1'b0;
				end
			endcase
		end
	end

	// SPI is served only in Standby, Normal and Forced Normal
	somc_spi_slave u_spi (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.sck_i     (spi_sck_i),
		.cs_n_i    (spi_cs_n_i),
		.sdi_i     (spi_sdi_i),
		.enable_i  (spi_enable),
		.rd_data_i (rd_data),
		.addr_o    (spi_addr),
		.wr_stb_o  (spi_wr_stb),
		.wr_data_o (spi_wr_data),
		.sdo_o     (spi_sdo_o),
		.sdo_oe_o  (spi_sdo_oe_o)
	);

endmodule

// ==== test/somc_chk.sv ====
`timescale 1ns/1ps
module somc_chk
	import somc_pkg::*;
(
	input wire logic       ref_clk_i,
	input wire logic       srst_i,
	input wire logic       battery_below_poweroff_i,
	input wire logic       temp_above_otp_act_i,
	input wire logic       temp_above_warn_i,
	input wire logic       regulator_undervolt_i,
	input wire logic       system_reset_line_o,
	input wire logic       system_reset_line_oe_o,
	input wire logic [2:0] watchdog_mode_field_i,
	input wire logic       overtemp_warning_enable_i,
	input wire logic       spi_sdo_oe_o,
	input wire logic       host_regulator_output_en_o,
	input wire logic       can_tx_en_o,
	input wire logic       can_rx_en_o,
	input wire logic       watchdog_run_o,
	input wire logic       watchdog_window_o,
	input wire logic       overtemp_warning_status_o,
	input wire logic       overtemp_warning_event_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (srst_i);
	// Regulator on and reset line released: Standby, Normal, Forced Normal, or Reset once its low time has passed
	wire act_mode = host_regulator_output_en_o && !system_reset_line_oe_o;
	sequence hot_s;
		temp_above_otp_act_i[*6];
	endsequence
	sequence warm_s;
		(temp_above_warn_i && host_regulator_output_en_o)[*5];
	endsequence
	a_line_pull_only: assert property (
		system_reset_line_oe_o |-> !system_reset_line_o)
		else $error("reset line driven high");
	a_reset_quiet: assert property (
		system_reset_line_oe_o && host_regulator_output_en_o |->
		!watchdog_run_o && !spi_sdo_oe_o && !can_rx_en_o)
		else $error("reset mode not quiet");
	a_bat_off_all: assert property (
		battery_below_poweroff_i[*6] |-> !host_regulator_output_en_o &&
		system_reset_line_oe_o && !can_tx_en_o && !can_rx_en_o)
		else $error("low battery not off");
	a_hot_reg_off: assert property (
		hot_s |-> !host_regulator_output_en_o && system_reset_line_oe_o &&
		!can_tx_en_o && !can_rx_en_o)
		else $error("overtemp outputs wrong");
	a_uv_held_reset: assert property (
		regulator_undervolt_i[*6] |->
		!watchdog_run_o && !can_tx_en_o && !spi_sdo_oe_o)
		else $error("undervoltage not held in reset");
	a_wd_active_only: assert property (
		watchdog_run_o |-> act_mode)
		else $error("watchdog runs outside active modes");
	a_spi_active_only: assert property (
		spi_sdo_oe_o |-> act_mode)
		else $error("data out driven while inactive");
	a_window_normal: assert property (
		watchdog_window_o |->
		act_mode && $past(watchdog_mode_field_i) == WMC_WINDOW)
		else $error("window watchdog unexpected");
	a_warn_status: assert property (
		warm_s |-> overtemp_warning_status_o)
		else $error("warning status missing");
	a_warn_event: assert property (
		$rose(overtemp_warning_event_o) |-> $past(overtemp_warning_enable_i))
		else $error("warning event while disabled");
endmodule

// ==== test/somc_host.sv ====
`timescale 1ns/1ps
module somc_host (
	input  wire logic sdo_i,
	input  wire logic sdo_oe_i,
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      sdi_o,
	output logic      pull_o
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
		pull_o = 1'b0;
	end
	// Idle data line keeps moving so stale bits are never read as data
	always #125 if (cs_n_o) sdi_o = ~sdi_o;
	// Address, read flag, data, MSB first
	task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
		cs_n_o = 1'b0;
		#125;
		for (int i = 15; i >= 0; i--) begin
			sdi_o = f[i];
			#62.5 sck_o = 1'b1;
			if (i < 8) rd[i] = sdo_oe_i ? sdo_i : ~sdo_i;
			#62.5 sck_o = 1'b0;
		end
		#125 cs_n_o = 1'b1;
		#250;
	endtask
	task automatic pull_reset(input int n);
		pull_o = 1'b1;
		#(n * 8);
		pull_o = 1'b0;
	endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
	import somc_pkg::*;
	localparam int SU = 20;
	logic        ref_clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        bat_on, bat_off, ot_act, ot_rel, warn, uv, wake;
	logic        wd_e, wd_o, wd_i, ow_en, ow_clr, rxbus;
	logic  [1:0] cmf;
	logic  [2:0] wmf;
	logic        rl_o, rl_oe, sdo, sdo_oe, reg_en, tx, rx, rxd;
	logic        wdr, wdw, ows, owe, sck, cs_n, sdi, pull;
	logic  [7:0] rd;
	logic [31:0] lf = 32'hBEFD;
	logic  [4:0] srcs [3] = '{RSS_WD_EARLY, RSS_WD_OVERFL, RSS_WD_ILLEGAL};
	int          n_mismatch = 0;
	int          checks = 0;
	wire         rline = (rl_oe ? rl_o : 1'b1) & !pull;
	wire   [1:0] mon = {reg_en, rl_oe};

	always #4 ref_clk_i = ~ref_clk_i;

	somc_mode_ctrl #(.STARTUP_CYCLES(SU)) u_somc_mode_ctrl (
		.ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.battery_above_poweron_i(bat_on), .battery_below_poweroff_i(bat_off),
		.temp_above_otp_act_i(ot_act), .temp_below_otp_rel_i(ot_rel),
		.temp_above_warn_i(warn), .regulator_undervolt_i(uv),
		.system_reset_line_i(rline), .system_reset_line_o(rl_o),
		.system_reset_line_oe_o(rl_oe), .wd_early_trigger_i(wd_e),
		.wd_overflow_i(wd_o), .wd_illegal_cfg_i(wd_i), .wake_pending_i(wake),
		.can_mode_field_i(cmf), .watchdog_mode_field_i(wmf),
		.overtemp_warning_enable_i(ow_en), .overtemp_warning_clear_i(ow_clr),
		.can_rx_bus_i(rxbus), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
		.spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
		.host_regulator_output_en_o(reg_en), .can_tx_en_o(tx),
		.can_rx_en_o(rx), .can_rxd_o(rxd), .watchdog_run_o(wdr),
		.watchdog_window_o(wdw), .overtemp_warning_status_o(ows),
		.overtemp_warning_event_o(owe)
	);
	somc_host u_somc_host (
		.sdo_i(sdo), .sdo_oe_i(sdo_oe), .sck_o(sck), .cs_n_o(cs_n),
		.sdi_o(sdi), .pull_o(pull)
	);

	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] stat(logic w, logic p, logic [4:0] s);
		return {1'b0, w, p, s};
	endfunction
	// Expected {transmit, receive} enables in Normal mode
	function automatic logic [1:0] can_en(logic [1:0] c);
		return (c == CMC_OFFLINE) ? 2'b00 : (c == CMC_LISTEN) ? 2'b01 : 2'b11;
	endfunction
	task automatic wrap_up();
		if (n_mismatch == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic wait_mon(input int w, input logic v, output int k);
		k = 0;
		while (mon[w] !== v) begin
			tick(1);
			k++;
			if (k > 4000) begin
				chk(8'h00, 8'h01);
				wrap_up();
			end
		end
	endtask
	// Wait for the reset line release and the mode that follows it
	task automatic back();
		int k;
		wait_mon(0, 1'b0, k);
		tick(6);
	endtask
	task automatic rreg(input logic [6:0] a, input logic [7:0] exp);
		u_somc_host.xfer({a, 1'b1, 8'h00}, rd);
		chk(rd, exp);
	endtask
	task automatic wreg(input logic [6:0] a, input logic [7:0] d);
		u_somc_host.xfer({a, 1'b0, d}, rd);
	endtask

	initial begin
		logic [2:0] c;
		int k;
		{bat_on, ot_act, warn, uv, wake, wd_e, wd_o, wd_i} = 8'h00;
		{ow_en, ow_clr, bat_off, ot_rel, rxbus} = 5'h07;
		cmf = CMC_OFFLINE;
		wmf = WMC_WINDOW;
		tick(3);
		srst_i = 1'b0;
		tick(8);
		chk({reg_en, rl_oe, tx, rx, wdr}, 8'h08);
		{bat_off, bat_on} = 2'b01;
		wait_mon(1, 1'b1, k);
		chk(k >= SU && k <= SU + 6, 1'b1);
		chk({rl_oe, sdo_oe, wdr, rx}, 8'h08);
		back();
		chk({tx, rx, wdr, reg_en}, 8'h0D);
		rreg(ADDR_MAIN_STATUS, stat(1'b0, 1'b1, RSS_POWER_ON));
		rreg(ADDR_MODE_CTRL, 8'h00);
		u_somc_host.pull_reset(8);
		tick(6);
		chk({tx, rx, wdr, rl_oe}, 8'h09);
		back();
		chk({tx, rx}, 8'h03);
		rreg(ADDR_MAIN_STATUS, stat(1'b0, 1'b1, RSS_EXT_PULL));
		wreg(ADDR_NV_CFG, 8'h00);
		{bat_off, bat_on} = 2'b10;
		tick(6);
		chk({reg_en, rl_oe, tx, rx, wdr}, 8'h08);
		{bat_off, bat_on} = 2'b01;
		wait_mon(1, 1'b1, k);
		back();
		chk({tx, rx, reg_en, wdr}, 8'h03);
		for (int i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			c = (i == 0) ? 3'h0 : lf[2:0];
			if (c == MC_NORMAL)
				c = 3'h5;
			wreg(ADDR_MODE_CTRL, {lf[7:3], c});
		end
		rreg(ADDR_MODE_CTRL, {5'h00, MC_STANDBY});
		chk({tx, rx, wdw}, 8'h00);
		wreg(ADDR_MODE_CTRL, {5'h00, MC_NORMAL});
		rreg(ADDR_MODE_CTRL, {5'h00, MC_NORMAL});
		rreg(ADDR_MAIN_STATUS, stat(1'b0, 1'b0, RSS_POWER_ON));
		chk({wdr, wdw}, 8'h03);
		for (int i = 0; i < 4; i++) begin
			cmf = i[1:0];
			lf = lfsr(lf);
			rxbus = lf[0];
			tick(6);
			chk({tx, rx}, can_en(cmf));
			if (cmf != CMC_OFFLINE)
				chk(rxd, rxbus);
		end
		cmf = CMC_OFFLINE;
		rxbus = 1'b1;
		wreg(ADDR_MODE_CTRL, {5'h00, MC_STANDBY});
		chk({wdr, wdw, tx}, 8'h04);
		for (int i = 0; i < 3; i++) begin
			wreg(ADDR_MODE_CTRL, {5'h00, MC_NORMAL});
			{wd_e, wd_o, wd_i} = 3'b100 >> i;
			tick(1);
			{wd_e, wd_o, wd_i} = 3'b000;
			tick(6);
			chk({wdr, sdo_oe, rl_oe}, 8'h01);
			back();
			rreg(ADDR_MAIN_STATUS, stat(1'b0, 1'b0, srcs[i]));
		end
		{ow_en, warn} = 2'b11;
		tick(6);
		chk({ows, owe}, 8'h03);
		rreg(ADDR_MAIN_STATUS, stat(1'b1, 1'b0, RSS_WD_ILLEGAL));
		{warn, ow_en, ow_clr} = 3'b001;
		tick(1);
		{warn, ow_clr} = 2'b10;
		tick(6);
		chk({ows, owe}, 8'h02);
		{warn, uv} = 2'b01;
		tick(3000);
		chk({wdr, sdo_oe, tx, rx}, 8'h00);
		uv = 1'b0;
		back();
		rreg(ADDR_MAIN_STATUS, stat(1'b0, 1'b0, RSS_V1_UV));
		{wake, ot_act, ot_rel} = 3'b110;
		tick(6);
		chk({reg_en, rl_oe, tx, rx, rxd}, 8'h08);
		{ot_act, ot_rel} = 2'b01;
		tick(6);
		chk({reg_en, rl_oe, rxd}, 8'h06);
		back();
		rreg(ADDR_MAIN_STATUS, stat(1'b0, 1'b0, RSS_OTP_EXIT));
		{wake, ot_act, ot_rel} = 3'b010;
		tick(6);
		{bat_off, bat_on} = 2'b10;
		tick(6);
		{ot_act, ot_rel} = 2'b01;
		tick(8);
		chk({reg_en, rl_oe}, 8'h01);
		wrap_up();
	end
endmodule

bind somc_mode_ctrl somc_chk u_somc_chk (
	.ref_clk_i                 (ref_clk_i),
	.srst_i                    (srst_i),
	.battery_below_poweroff_i  (battery_below_poweroff_i),
	.temp_above_otp_act_i      (temp_above_otp_act_i),
	.temp_above_warn_i         (temp_above_warn_i),
	.regulator_undervolt_i     (regulator_undervolt_i),
	.system_reset_line_o       (system_reset_line_o),
	.system_reset_line_oe_o    (system_reset_line_oe_o),
	.watchdog_mode_field_i     (watchdog_mode_field_i),
	.overtemp_warning_enable_i (overtemp_warning_enable_i),
	.spi_sdo_oe_o              (spi_sdo_oe_o),
	.host_regulator_output_en_o(host_regulator_output_en_o),
	.can_tx_en_o               (can_tx_en_o),
	.can_rx_en_o               (can_rx_en_o),
	.watchdog_run_o            (watchdog_run_o),
	.watchdog_window_o         (watchdog_window_o),
	.overtemp_warning_status_o (overtemp_warning_status_o),
	.overtemp_warning_event_o  (overtemp_warning_event_o)
);
